// File: logic/abc_adaptive_boost.sv
`timescale 1ns/1ps
`include "abc_consts.svh"

// Notes on behaviour
// R1: Bit 3 of the control register turns on the adaptive boost loop.
// R2: When adaptive, the boost setting is the start of the target and, except on an up step, its floor.
// R3: The LOW threshold is offset plus 875 mV minus 125 mV per headroom code.
// R4: The MID threshold combines the headroom code with the hysteresis field.
// R5: The up step is 105, 210, 420 or 840 mV for codes 00 to 11.
// R6: The down step uses the same encoding in its own field.
// R7: The HIGH fault threshold is 5, 4, 3 or 2 V for codes 00 to 11.
// R8: An 8-bit read/write revision field fills the revision register.
// R9: The loop steps up below LOW headroom and steps down above MID headroom.
module abc_adaptive_boost (
    input wire logic sys_clk,
    input wire logic reset_n,
    input abc_pkg::abc_reg_req_t reg_req,
    input wire logic [5:0] boost_voltage_setting,
    input wire logic [15:0] headroom_mv,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    output logic spread_spectrum_enable_q,
    output logic adaptive_active_q,
    output logic [15:0] boost_target_mv_q,
    output logic [15:0] low_threshold_mv_q,
    output logic [15:0] mid_threshold_mv_q,
    output logic [15:0] high_threshold_mv_q,
    output logic [7:0] settings_revision_id_q
);
    import abc_pkg::*;

    logic [7:0] adaptive_boost_control_q, adaptive_boost_control_d;
    logic [7:0] headroom_step_threshold_q, headroom_step_threshold_d;
    logic [7:0] settings_revision_d;
    logic [7:0] rdata_d;
    logic rvalid_d;
    abc_control_t ctrl;
    abc_step_t step;
    abc_thresh_t th;

    // Register writes; unmapped offsets are ignored
    always_comb begin
        adaptive_boost_control_d = adaptive_boost_control_q;
        headroom_step_threshold_d = headroom_step_threshold_q;
        settings_revision_d = settings_revision_id_q;
        if (reg_req.wr && reg_req.addr == `ABC_OFS_CONTROL) begin
            adaptive_boost_control_d = reg_req.wdata; // R1
        end else if (reg_req.wr && reg_req.addr == `ABC_OFS_STEP) begin
            headroom_step_threshold_d = reg_req.wdata; // R5
        end else if (reg_req.wr && reg_req.addr == `ABC_OFS_REVISION) begin
            settings_revision_d = reg_req.wdata; // R8
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            adaptive_boost_control_q <= `ABC_RST_CONTROL;
            headroom_step_threshold_q <= `ABC_RST_STEP;
            settings_revision_id_q <= `ABC_RST_REVISION;
        end else begin
            adaptive_boost_control_q <= adaptive_boost_control_d;
            headroom_step_threshold_q <= headroom_step_threshold_d;
            settings_revision_id_q <= settings_revision_d;
        end
    end

    // A read on the same edge as a write returns the old value
    always_comb begin
        rvalid_d = reg_req.rd;
        if (!reg_req.rd) begin
            // Read data stands until the next read
            rdata_d = reg_rdata_q;
        end else if (reg_req.addr == `ABC_OFS_CONTROL) begin
            rdata_d = adaptive_boost_control_q;
        end else if (reg_req.addr == `ABC_OFS_STEP) begin
            rdata_d = headroom_step_threshold_q;
        end else if (reg_req.addr == `ABC_OFS_REVISION) begin
            rdata_d = settings_revision_id_q; // R8
        end else begin
            // Unmapped offsets read as zero
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q <= rdata_d;
            reg_rvalid_q <= rvalid_d;
        end
    end

    // Reserved control bits 6:4 are stored and read back but drive nothing
    assign ctrl.spread_spectrum_enable =
        adaptive_boost_control_q[`ABC_SPREAD_BIT];
    assign ctrl.adaptive_enable = adaptive_boost_control_q[`ABC_ADAPTIVE_BIT];
    assign ctrl.driver_headroom_code =
        adaptive_boost_control_q[`ABC_HEADROOM_LSB +: 3];
    assign step.upper_increment =
        headroom_step_threshold_q[`ABC_STEP_UP_LSB +: 2];
    assign step.lower_decrement =
        headroom_step_threshold_q[`ABC_LOWER_DECREMENT_LSB +: 2];
    assign step.high_threshold_code =
        headroom_step_threshold_q[`ABC_HIGH_TH_LSB +: 2];
    assign step.mid_hysteresis_code =
        headroom_step_threshold_q[`ABC_HYST_LSB +: 2];

    abc_thresh_decode u_decode (
        .ctrl(ctrl),
        .step(step),
        .th(th)
    );

    // Adaptive loop
    abc_loop_state_t loop_move;
    logic [15:0] floor_mv;
    logic [15:0] down_reach_mv;
    logic [16:0] raised;
    logic [15:0] lowered;
    logic [15:0] boost_target_mv_d;
    logic en_prev_q;
    logic en_prev_d;

    // Status outputs
    logic adaptive_active_d;
    logic spread_spectrum_enable_d;
    logic [15:0] low_threshold_mv_d;
    logic [15:0] mid_threshold_mv_d;
    logic [15:0] high_threshold_mv_d;

    assign floor_mv =
        16'(`ABC_BOOST_LSB_MV * {10'h000, boost_voltage_setting});
    // One extra bit so a raise near full scale saturates instead of wrapping
    assign raised = {1'b0, boost_target_mv_q} + {1'b0, th.up_mv};
    assign lowered = boost_target_mv_q - th.down_mv;
    // At most 6300 plus 840 mV, so the sum fits in 16 bits
    assign down_reach_mv = floor_mv + th.down_mv;

    always_comb begin
        loop_move = ABC_IDLE;
        en_prev_d = ctrl.adaptive_enable;
        boost_target_mv_d = boost_target_mv_q;
        if (!ctrl.adaptive_enable) begin
            // Open loop follows the plain boost setting
            boost_target_mv_d = floor_mv;
        end else if (!en_prev_q) begin
            // First enabled cycle starts from the programmed setting
            boost_target_mv_d = floor_mv; // R2
        end else if (headroom_mv < th.low_mv) begin
            loop_move = ABC_RAISE; // R9
        end else if (headroom_mv > th.mid_mv) begin
            loop_move = ABC_LOWER; // R9
        end
        case (loop_move)
            ABC_RAISE: begin
                // Saturate rather than wrap on a runaway loop
                if (raised[16]) begin
                    boost_target_mv_d = 16'hffff; // R5
                end else begin
                    boost_target_mv_d = raised[15:0]; // R5
                end
            end
            ABC_LOWER: begin
                // Never go below the programmed boost setting
                if (boost_target_mv_q < down_reach_mv) begin
                    boost_target_mv_d = floor_mv; // R2
                end else begin
                    boost_target_mv_d = lowered; // R6
                end
            end
            ABC_IDLE: begin
                // A setting raised while the loop runs lifts the target
                if (ctrl.adaptive_enable && boost_target_mv_q < floor_mv) begin
                    boost_target_mv_d = floor_mv; // R2
                end
            end
            default: begin
                // Unreachable with one-hot codes; fall back to open loop
                boost_target_mv_d = floor_mv;
            end
        endcase
    end

    // Target resets to zero; the first clock after release loads the floor
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_prev_q <= 1'b0;
            boost_target_mv_q <= 16'h0000;
        end else begin
            en_prev_q <= en_prev_d;
            boost_target_mv_q <= boost_target_mv_d;
        end
    end

    // Status outputs lag the control register by one clock
    always_comb begin
        adaptive_active_d = ctrl.adaptive_enable; // R1
        spread_spectrum_enable_d = ctrl.spread_spectrum_enable;
        low_threshold_mv_d = th.low_mv; // R3
        mid_threshold_mv_d = th.mid_mv; // R4
        high_threshold_mv_d = th.high_mv; // R7
    end

    // Thresholds are registered so that every output comes from a flip-flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            adaptive_active_q <= 1'b0;
            spread_spectrum_enable_q <= 1'b0;
            low_threshold_mv_q <= 16'h0000;
            mid_threshold_mv_q <= 16'h0000;
            high_threshold_mv_q <= 16'h0000;
        end else begin
            adaptive_active_q <= adaptive_active_d;
            spread_spectrum_enable_q <= spread_spectrum_enable_d;
            low_threshold_mv_q <= low_threshold_mv_d;
            mid_threshold_mv_q <= mid_threshold_mv_d;
            high_threshold_mv_q <= high_threshold_mv_d;
        end
    end

endmodule : abc_adaptive_boost

// File: logic/abc_consts.svh
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH

// Register offsets on the device register port
`define ABC_OFS_CONTROL 8'haa
`define ABC_OFS_STEP 8'hae
`define ABC_OFS_REVISION 8'haf

// Control register field positions
`define ABC_SPREAD_BIT 7
`define ABC_ADAPTIVE_BIT 3
`define ABC_HEADROOM_LSB 0

// Step and threshold register field positions
`define ABC_STEP_UP_LSB 6
`define ABC_LOWER_DECREMENT_LSB 4
`define ABC_HIGH_TH_LSB 2
`define ABC_HYST_LSB 0

// Reset values
`define ABC_RST_CONTROL 8'h00
`define ABC_RST_STEP 8'h00
`define ABC_RST_REVISION 8'h00

// Threshold arithmetic in millivolts
`define ABC_LOW_TOP_MV 16'h036b
`define ABC_LOW_STEP_MV 16'h007d
`define ABC_STEP_BASE_MV 16'h0069
`define ABC_HIGH_TOP_MV 16'h1388
`define ABC_HIGH_STEP_MV 16'h03e8
`define ABC_HYST_TOP_MV 16'h03e8
`define ABC_HYST_STEP_MV 16'h00fa

// Boost target in millivolts per code of the boost voltage setting
`define ABC_BOOST_LSB_MV 16'h0064

`endif

// File: logic/abc_pkg.sv
package abc_pkg;

    typedef struct packed {
        logic spread_spectrum_enable;
        logic adaptive_enable;
        logic [2:0] driver_headroom_code;
    } abc_control_t;

    typedef struct packed {
        logic [1:0] upper_increment;
        logic [1:0] lower_decrement;
        logic [1:0] high_threshold_code;
        logic [1:0] mid_hysteresis_code;
    } abc_step_t;

    typedef struct packed {
        logic [15:0] low_mv;
        logic [15:0] mid_mv;
        logic [15:0] high_mv;
        logic [15:0] up_mv;
        logic [15:0] down_mv;
    } abc_thresh_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } abc_reg_req_t;

    typedef enum logic [2:0] {
        ABC_IDLE = 3'b001,
        ABC_RAISE = 3'b010,
        ABC_LOWER = 3'b100
    } abc_loop_state_t;

endpackage : abc_pkg

// File: logic/abc_thresh_decode.sv
`timescale 1ns/1ps
`include "abc_consts.svh"

module abc_thresh_decode (
    input abc_pkg::abc_control_t ctrl,
    input abc_pkg::abc_step_t step,
    output abc_pkg::abc_thresh_t th
);
    import abc_pkg::*;

    function automatic logic [15:0] step_mv(input logic [1:0] code);
        step_mv = `ABC_STEP_BASE_MV << code;
    endfunction : step_mv

    always_comb begin
        // Offset relative: code 000 is top, each code takes one step off
        th.low_mv = `ABC_LOW_TOP_MV - 16'(`ABC_LOW_STEP_MV *
            {13'h0000, ctrl.driver_headroom_code}); // R3
        th.mid_mv = th.low_mv + `ABC_HYST_TOP_MV - 16'(`ABC_HYST_STEP_MV *
            {14'h0000, step.mid_hysteresis_code}); // R4
        th.high_mv = `ABC_HIGH_TOP_MV - 16'(`ABC_HIGH_STEP_MV *
            {14'h0000, step.high_threshold_code}); // R7
        th.up_mv = step_mv(step.upper_increment); // R5
        th.down_mv = step_mv(step.lower_decrement); // R6
    end

endmodule : abc_thresh_decode

// File: tb/abc_checker.sv
`timescale 1ns/1ps
module abc_checker (
    input logic sys_clk,
    input logic reset_n,
    input abc_pkg::abc_reg_req_t reg_req,
    input logic [5:0] boost_voltage_setting,
    input logic reg_rvalid_q,
    input logic adaptive_active_q,
    input logic [15:0] boost_target_mv_q,
    input logic [15:0] low_threshold_mv_q,
    input logic [15:0] mid_threshold_mv_q,
    input logic [15:0] high_threshold_mv_q,
    input logic [7:0] settings_revision_id_q
);
    import abc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_read_answer: assert property (
        reg_rvalid_q == $past(reg_req.rd)) else $error("bad read valid");
    a_adapt_enable: assert property (
        reg_req.wr && reg_req.addr == 8'haa ##1 !reg_req.wr |=>
        adaptive_active_q == $past(reg_req.wdata[3], 2))
        else $error("bad adaptive enable");
    a_target_floor: assert property (
        adaptive_active_q && $stable(boost_voltage_setting) |->
        boost_target_mv_q >= boost_voltage_setting * 16'h0064)
        else $error("target below floor");
    a_low_code: assert property (
        low_threshold_mv_q <= 16'h036b &&
        (16'h036b - low_threshold_mv_q) % 16'h007d == 16'h0000)
        else $error("bad low threshold");
    // Outputs still show the reset zeros at the first edge after release
    a_mid_offset: assert property (
        $past(reset_n) |-> mid_threshold_mv_q - low_threshold_mv_q inside
        {16'h03e8, 16'h02ee, 16'h01f4, 16'h00fa}) else $error("bad mid");
    a_high_code: assert property (
        $past(reset_n) |-> high_threshold_mv_q inside
        {16'h1388, 16'h0fa0, 16'h0bb8, 16'h07d0}) else $error("bad high");
    a_step_up: assert property (
        adaptive_active_q && $past(adaptive_active_q) &&
        boost_target_mv_q > $past(boost_target_mv_q) |->
        boost_target_mv_q == 16'hffff ||
        boost_target_mv_q - $past(boost_target_mv_q) inside
        {16'h0069, 16'h00d2, 16'h01a4, 16'h0348}) else $error("bad up step");
    a_step_down: assert property (
        adaptive_active_q && $past(adaptive_active_q) &&
        boost_target_mv_q < $past(boost_target_mv_q) |->
        boost_target_mv_q == boost_voltage_setting * 16'h0064 ||
        $past(boost_target_mv_q) - boost_target_mv_q inside
        {16'h0069, 16'h00d2, 16'h01a4, 16'h0348}) else $error("bad down step");
    a_rev_write: assert property (
        reg_req.wr && reg_req.addr == 8'haf |=>
        settings_revision_id_q == $past(reg_req.wdata))
        else $error("bad revision");
endmodule : abc_checker

bind abc_adaptive_boost abc_checker chk_u (.sys_clk, .reset_n, .reg_req,
    .boost_voltage_setting, .reg_rvalid_q, .adaptive_active_q,
    .boost_target_mv_q, .low_threshold_mv_q, .mid_threshold_mv_q,
    .high_threshold_mv_q, .settings_revision_id_q);

// File: tb/abc_host.sv
`timescale 1ns/1ps
module abc_host (
    input logic sys_clk,
    output abc_pkg::abc_reg_req_t reg_req
);
    import abc_pkg::*;
    initial reg_req = '0;
    // Released address and data are inverted so stale values never match
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk) #1;
        reg_req = {w, !w, a, d};
        @(posedge sys_clk) #1;
        reg_req = {2'b00, ~a, ~d};
    endtask : access
endmodule : abc_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import abc_pkg::*;
    logic sys_clk, reset_n, rvalid, act, ssen;
    logic [15:0] headroom_mv, tgt, low, mid, high;
    logic [7:0] rdata, settings_revision_id;
    logic [5:0] boost;
    abc_reg_req_t reg_req;
    integer mismatches = 0, tests_run = 0, seed = 6, cycles = 0, t, i;
    integer regs [logic [7:0]];
    abc_host host_u (.sys_clk(sys_clk), .reg_req(reg_req));
    abc_adaptive_boost dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_req(reg_req), .boost_voltage_setting(boost),
        .headroom_mv(headroom_mv), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
        .spread_spectrum_enable_q(ssen), .adaptive_active_q(act),
        .boost_target_mv_q(tgt), .low_threshold_mv_q(low),
        .mid_threshold_mv_q(mid), .high_threshold_mv_q(high),
        .settings_revision_id_q(settings_revision_id));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic check(input string n, input logic [15:0] e, s);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        host_u.access(1'b1, a, d);
        if (regs.exists(a)) regs[a] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host_u.access(1'b0, a, 8'h00);
        // Answer stands for one cycle after the edge that took the read
        check("rvalid", 16'h0001, 16'(rvalid));
        check("rdata", regs.exists(a) ? regs[a] : 0, rdata);
    endtask : rd
    task automatic check_th;
        t = 875 - 125 * (regs[8'haa] & 7);
        check("low", t, low);
        check("mid", t + 1000 - 250 * (regs[8'hae] & 3), mid);
        check("high", 5000 - 1000 * ((regs[8'hae] >> 2) & 3), high);
        check("revision", regs[8'haf], settings_revision_id);
        check("spread", (regs[8'haa] >> 7) & 1, 16'(ssen));
    endtask : check_th
    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        headroom_mv = 16'h0000;
        boost = 6'h14;
        reset_n = 0;
        regs[8'haa] = 0;
        regs[8'hae] = 0;
        regs[8'haf] = 0;
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1;
        @(posedge sys_clk) #1;
        check_th;
        foreach (regs[k]) rd(k);
        for (i = 0; i < 6; i++) begin
            // Adaptive kept off here; the loop scenario below owns it
            wr(8'haa, 8'($random(seed)) & 8'hf7);
            wr(8'hae, 8'($random(seed)));
            wr(8'haf, 8'($random(seed)));
            wr(8'h3c, 8'($random(seed)));
            check_th;
            foreach (regs[k]) rd(k);
            rd(8'h3c);
        end
        for (i = 0; i < 4; i++) begin
            // Setting changes only while the loop is off
            wr(8'haa, 8'h00);
            boost = 6'($random(seed));
            headroom_mv = 16'h0000;
            wr(8'hae, 8'(i * 8'h50));
            wr(8'haa, 8'h08);
            @(posedge sys_clk) #1;
            check("active", 16'h0001, 16'(act));
            t = 100 * boost;
            check("start", t, tgt);
            repeat (4) begin
                @(posedge sys_clk) #1 t = t + (105 << i);
                check("raise", t, tgt);
            end
            headroom_mv = 16'hffff;
            // One step more than the raises, so the floor clamp is reached
            repeat (5) begin
                @(posedge sys_clk) #1 t = t - (105 << i);
                if (t < 100 * boost) t = 100 * boost;
                check("lower", t, tgt);
            end
        end
        finish_test;
    end
endmodule : tb_top
